// *** afr_consts.svh ***
// constants for the api frame relay and update engine
// assumes frames travel as byte streams starting at the frame-type byte
`ifndef AFR_CONSTS_SVH
`define AFR_CONSTS_SVH
// ---------------------------------------------
// frame types and codes
// ---------------------------------------------
`define AFR_T_SOCK_RX 8'hb0
`define AFR_T_RELAY_REQ 8'h2d
`define AFR_T_RELAY_OUT 8'had
`define AFR_T_TX_STATUS 8'h89
`define AFR_T_FW_REQ 8'h2b
`define AFR_T_FW_RESP 8'hab
`define AFR_ST_BAD_IF 8'h7c
`define AFR_ST_BUSY_IF 8'h7d
`define AFR_PROTO_UDP 8'h00
`define AFR_PROTO_TCP 8'h01
`define AFR_PROTO_SSL 8'h04
`define AFR_RSVD_STATUS 8'h00
`define AFR_SOCK_HDR_LEN 4'hb
`define AFR_DST_MAX 8'h02
`define AFR_FW_OK 8'h00
`define AFR_FW_CANCELLED 8'h01
`define AFR_FW_IN_PROG 8'h02
`define AFR_FW_NOT_START 8'h03
`define AFR_FW_SEQ_ERR 8'h04
`define AFR_FW_INTERNAL 8'h05
`define AFR_FW_RESOURCE 8'h06
`define AFR_FL_INIT 0
`define AFR_FL_FINAL 1
`define AFR_FL_CANCEL 2
// ---------------------------------------------
// wishbone register map
// ---------------------------------------------
`define AFR_REG_CTRL 8'h00
`define AFR_REG_STATUS 8'h04
`define AFR_REG_COUNT 8'h08
`define AFR_CTRL_RST 8'hf1
`define AFR_CTRL_EN_BIT 0
`endif

// *** afr_host_model.sv ***
// egress sink standing in for the host side of the frame engine
// assumes one clock shared with the engine and a bench that reads cap_q
`timescale 1ns/1ps
`default_nettype none
module afr_host_model (
   // clock
   input wire logic i_mclk,
   // egress stream from the engine
   input wire logic i_valid,
   input wire logic [7:0] i_data,
   input wire logic i_last,
   input wire logic [1:0] i_dst,
   // stall request from the bench
   input wire logic i_stall,
   output logic o_ready
);
   // ---------------------------------------------
   // capture
   // ---------------------------------------------
   logic [10:0] cap_q[$];
   logic [2:0] ph_q;
   initial begin
      o_ready = 1'b0;
      ph_q = 3'h0;
   end
   // ready every other cycle when stalling, to catch outputs not held
   always @(posedge i_mclk) begin
      ph_q <= ph_q + 3'h1;
      o_ready <= !i_stall || ph_q[0];
      if (i_valid && o_ready)
         cap_q.push_back({i_last, i_dst, i_data});
   end
endmodule
`default_nettype wire

// *** afr_pkg.sv ***
// types for the api frame relay and update engine
// assumes afr_consts.svh supplies the numeric constants
package afr_pkg;
   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef enum logic [1:0] {
      AFR_UDP = 2'h0,
      AFR_TCP = 2'h1,
      AFR_SSL = 2'h2
   } afr_proto_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_TAKE = 5'b00010,
      ST_HDR = 5'b00100,
      ST_SKP = 5'b01000,
      ST_SKDROP = 5'b10000
   } afr_state_t;
   typedef enum logic [4:0] {
      K_TYPE = 5'b00001,
      K_RELAY = 5'b00010,
      K_FW = 5'b00100,
      K_PASS = 5'b01000,
      K_DROP = 5'b10000
   } afr_kind_t;
endpackage

// *** afr_top.sv ***
// frame engine: socket receive framing, data relay, update requests
// assumes i_in_src is stable for a whole ingress frame
`include "afr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module afr_top #(
   parameter int P_MAX_PAYLOAD = 1500,
   parameter int P_AW = 8
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [P_AW-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   // socket packet header and payload
   input wire logic i_sk_valid,
   input wire logic [31:0] i_sk_ip,
   input wire logic [15:0] i_sk_lport,
   input wire logic [15:0] i_sk_rport,
   input wire afr_pkg::afr_proto_t i_sk_kind,
   output logic o_sk_start,
   input wire logic i_sk_dvalid,
   input wire logic [7:0] i_sk_data,
   input wire logic i_sk_dlast,
   output logic o_sk_dready,
   // ingress frames from serial, ble or script
   input wire logic i_in_valid,
   input wire logic [7:0] i_in_data,
   input wire logic i_in_last,
   input wire logic [1:0] i_in_src,
   output logic o_in_ready,
   // destination readiness, bit 3 is the update store
   input wire logic [3:0] i_dst_accept,
   // egress frames, tagged with destination
   output logic o_out_valid,
   output logic [7:0] o_out_data,
   output logic o_out_last,
   output logic [1:0] o_out_dst,
   input wire logic i_out_ready
);
   import afr_pkg::*;
   localparam int CW = $clog2(P_MAX_PAYLOAD + 1);
   generate
      if (P_MAX_PAYLOAD < 1 || P_MAX_PAYLOAD > 4095) begin : g_bad
         $error("P_MAX_PAYLOAD out of range");
      end
      // register decode reads eight address bits
      if (P_AW < 8) begin : g_bad_aw
         $error("P_AW below eight");
      end
   endgenerate

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   afr_state_t st_q, st_d, hdr_next_q;
   afr_kind_t kind_q;
   logic [1:0] idx_q;
   logic [7:0] hdr_q [0:10];
   logic [3:0] hdr_n_q, hdr_i_q;
   logic hdr_last_q;
   logic [1:0] route_q;
   logic [7:0] rl_id_q, fw_id_q, fw_exp_q, fw_stat_q;
   logic fw_active_q, fw_pend_q;
   logic [CW-1:0] sk_cnt_q;
   logic [7:0] ctrl_q;
   logic [15:0] cnt_err_q, cnt_sk_q;
   logic o_in_ready_q, o_sk_dready_q, o_sk_start_q;
   logic o_out_valid_q, o_out_last_q;
   logic [7:0] o_out_data_q;
   logic [1:0] o_out_dst_q;
   logic o_wb_ack_q;
   logic [31:0] o_wb_dat_q;

   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   logic en, in_take, sk_take, sk_begin, is_dest, bad_if, busy_if;
   logic relay_ok, err_fire, fw_flags, respond_fire, hdr_emit, out_load;
   logic [3:0] acc;
   logic [7:0] fw_st_d, resp_st, err_code, out_d;
   logic out_last_d;

   assign en = ctrl_q[`AFR_CTRL_EN_BIT];
   assign acc = i_dst_accept & ctrl_q[7:4];
   assign in_take = (st_q == ST_TAKE) && o_in_ready_q && i_in_valid;
   assign sk_take = (st_q == ST_SKP || st_q == ST_SKDROP) &&
                    o_sk_dready_q && i_sk_dvalid;
   assign sk_begin = (st_q == ST_IDLE) && en && i_sk_valid;
   assign is_dest = in_take && kind_q == K_RELAY && idx_q == 2'h2;
   assign bad_if = i_in_data > `AFR_DST_MAX;
   assign busy_if = !bad_if && !acc[i_in_data[1:0]];
   assign relay_ok = is_dest && !bad_if && !busy_if;
   // zero id keeps the error silent
   assign err_fire = is_dest && (bad_if || busy_if) &&
                     rl_id_q != 8'h00;
   assign err_code = bad_if ? `AFR_ST_BAD_IF : `AFR_ST_BUSY_IF;
   assign fw_flags = in_take && kind_q == K_FW && idx_q == 2'h3;
   assign respond_fire = in_take && i_in_last &&
                         (kind_q == K_FW || fw_pend_q);
   assign hdr_emit = (st_q == ST_HDR) && !o_out_valid_q;

   // update status from flags byte
   always_comb begin
      fw_st_d = `AFR_FW_OK;
      if (i_in_data[`AFR_FL_CANCEL]) begin
         fw_st_d = fw_active_q ? `AFR_FW_CANCELLED : `AFR_FW_NOT_START;
      end else if (i_in_data[`AFR_FL_INIT]) begin
         if (fw_active_q)
            fw_st_d = `AFR_FW_IN_PROG;
         else if (!acc[3])
            fw_st_d = `AFR_FW_RESOURCE;
      end else if (!fw_active_q) begin
         fw_st_d = `AFR_FW_NOT_START;
      end else if (fw_id_q != fw_exp_q) begin
         fw_st_d = `AFR_FW_SEQ_ERR;
      end else if (!acc[3]) begin
         fw_st_d = `AFR_FW_RESOURCE;
      end
   end

   // short update frames end before flags and count as internal errors
   always_comb begin
      if (fw_flags)
         resp_st = fw_st_d;
      else if (kind_q == K_FW)
         resp_st = `AFR_FW_INTERNAL;
      else
         resp_st = fw_stat_q;
   end

   // ---------------------------------------------
   // sequencer
   // ---------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (sk_begin)
               st_d = ST_HDR;
            else if (en && i_in_valid)
               st_d = ST_TAKE;
         end
         ST_TAKE: begin
            if (in_take) begin
               if (relay_ok || err_fire || respond_fire)
                  st_d = ST_HDR;
               else if (i_in_last)
                  st_d = ST_IDLE;
            end
         end
         ST_HDR: begin
            if (hdr_emit && hdr_i_q == hdr_n_q - 4'h1)
               st_d = hdr_next_q;
         end
         ST_SKP: begin
            if (sk_take && i_sk_dlast)
               st_d = ST_IDLE;
            else if (sk_take && sk_cnt_q == CW'(P_MAX_PAYLOAD - 1))
               st_d = ST_SKDROP;
         end
         ST_SKDROP: begin
            if (sk_take && i_sk_dlast)
               st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n)
         st_q <= ST_IDLE;
      else
         st_q <= st_d;
   end

   // ---------------------------------------------
   // ingress frame parsing
   // ---------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         kind_q <= K_TYPE;
         idx_q <= 2'h0;
         rl_id_q <= 8'h00;
         fw_id_q <= 8'h00;
         fw_pend_q <= 1'b0;
      end else if (st_q == ST_IDLE) begin
         kind_q <= K_TYPE;
         idx_q <= 2'h0;
         fw_pend_q <= 1'b0;
      end else if (in_take) begin
         if (idx_q != 2'h3)
            idx_q <= idx_q + 2'h1;
         if (i_in_last)
            fw_pend_q <= 1'b0;
         case (kind_q)
            K_TYPE: begin
               if (i_in_data == `AFR_T_RELAY_REQ)
                  kind_q <= K_RELAY;
               else if (i_in_data == `AFR_T_FW_REQ)
                  kind_q <= K_FW;
               else
                  kind_q <= K_DROP;
            end
            K_RELAY: begin
               if (idx_q == 2'h1)
                  rl_id_q <= i_in_data;
               if (idx_q == 2'h2)
                  kind_q <= relay_ok ? K_PASS : K_DROP;
            end
            K_FW: begin
               if (idx_q == 2'h1)
                  fw_id_q <= i_in_data;
               if (idx_q == 2'h3) begin
                  kind_q <= (fw_st_d == `AFR_FW_OK) ? K_PASS : K_DROP;
                  fw_pend_q <= !i_in_last;
               end
            end
            default: kind_q <= kind_q;
         endcase
      end
   end

   // update session tracking
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         fw_active_q <= 1'b0;
         fw_exp_q <= 8'h00;
         fw_stat_q <= `AFR_FW_OK;
      end else if (fw_flags) begin
         fw_stat_q <= fw_st_d;
         if (i_in_data[`AFR_FL_CANCEL]) begin
            fw_active_q <= 1'b0;
         end else if (fw_st_d == `AFR_FW_OK) begin
            fw_exp_q <= fw_id_q + 8'h01;
            fw_active_q <= !i_in_data[`AFR_FL_FINAL];
         end
      end
   end

   // ---------------------------------------------
   // header staging
   // ---------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         for (int k = 0; k < 11; k++)
            hdr_q[k] <= 8'h00;
         hdr_n_q <= 4'h0;
         hdr_i_q <= 4'h0;
         hdr_last_q <= 1'b0;
         hdr_next_q <= ST_IDLE;
         route_q <= 2'h0;
      end else if (sk_begin) begin
         hdr_q[0] <= `AFR_T_SOCK_RX;
         hdr_q[1] <= i_sk_ip[31:24];
         hdr_q[2] <= i_sk_ip[23:16];
         hdr_q[3] <= i_sk_ip[15:8];
         hdr_q[4] <= i_sk_ip[7:0];
         hdr_q[5] <= i_sk_lport[15:8];
         hdr_q[6] <= i_sk_lport[7:0];
         hdr_q[7] <= i_sk_rport[15:8];
         hdr_q[8] <= i_sk_rport[7:0];
         case (i_sk_kind)
            AFR_TCP: hdr_q[9] <= `AFR_PROTO_TCP;
            AFR_SSL: hdr_q[9] <= `AFR_PROTO_SSL;
            default: hdr_q[9] <= `AFR_PROTO_UDP;
         endcase
         hdr_q[10] <= `AFR_RSVD_STATUS;
         hdr_n_q <= `AFR_SOCK_HDR_LEN;
         hdr_i_q <= 4'h0;
         hdr_last_q <= 1'b0;
         hdr_next_q <= ST_SKP;
         route_q <= 2'h0;
      end else if (err_fire) begin
         hdr_q[0] <= `AFR_T_TX_STATUS;
         hdr_q[1] <= rl_id_q;
         hdr_q[2] <= err_code;
         hdr_n_q <= 4'h3;
         hdr_i_q <= 4'h0;
         hdr_last_q <= 1'b1;
         hdr_next_q <= i_in_last ? ST_IDLE : ST_TAKE;
         route_q <= i_in_src;
      end else if (relay_ok) begin
         hdr_q[0] <= `AFR_T_RELAY_OUT;
         hdr_q[1] <= {6'h00, i_in_src};
         hdr_n_q <= 4'h2;
         hdr_i_q <= 4'h0;
         hdr_last_q <= i_in_last;
         hdr_next_q <= i_in_last ? ST_IDLE : ST_TAKE;
         route_q <= i_in_data[1:0];
      end else if (respond_fire) begin
         hdr_q[0] <= `AFR_T_FW_RESP;
         hdr_q[1] <= fw_id_q;
         hdr_q[2] <= resp_st;
         hdr_n_q <= 4'h3;
         hdr_i_q <= 4'h0;
         hdr_last_q <= 1'b1;
         hdr_next_q <= ST_IDLE;
         route_q <= i_in_src;
      end else if (fw_flags && fw_st_d == `AFR_FW_OK) begin
         route_q <= 2'h3;
      end else if (hdr_emit) begin
         hdr_i_q <= hdr_i_q + 4'h1;
      end
   end

   // ---------------------------------------------
   // egress register and handshakes
   // ---------------------------------------------
   assign out_load = hdr_emit || (in_take && kind_q == K_PASS) ||
                     (sk_take && st_q == ST_SKP);

   always_comb begin
      out_d = i_in_data;
      out_last_d = i_in_last;
      if (hdr_emit) begin
         out_d = hdr_q[hdr_i_q];
         out_last_d = hdr_last_q && hdr_i_q == hdr_n_q - 4'h1;
      end else if (st_q == ST_SKP) begin
         out_d = i_sk_data;
         // the cap closes the frame early; the rest is drained unseen
         out_last_d = i_sk_dlast ||
                      sk_cnt_q == CW'(P_MAX_PAYLOAD - 1);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_out_valid_q <= 1'b0;
         o_out_data_q <= 8'h00;
         o_out_last_q <= 1'b0;
         o_out_dst_q <= 2'h0;
      end else if (out_load) begin
         o_out_valid_q <= 1'b1;
         o_out_data_q <= out_d;
         o_out_last_q <= out_last_d;
         o_out_dst_q <= route_q;
      end else if (i_out_ready) begin
         o_out_valid_q <= 1'b0;
      end
   end

   // one byte in flight keeps ready a plain flop, at one byte per three cycles when forwarding, per two when dropping
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_in_ready_q <= 1'b0;
         o_sk_dready_q <= 1'b0;
         o_sk_start_q <= 1'b0;
      end else begin
         o_in_ready_q <= st_q == ST_TAKE && !in_take && !o_out_valid_q;
         o_sk_dready_q <= ((st_q == ST_SKP && !o_out_valid_q) ||
                           st_q == ST_SKDROP) && !sk_take;
         o_sk_start_q <= sk_begin;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n)
         sk_cnt_q <= '0;
      else if (sk_begin)
         sk_cnt_q <= '0;
      else if (sk_take && st_q == ST_SKP)
         sk_cnt_q <= sk_cnt_q + CW'(1);
   end

   // ---------------------------------------------
   // wishbone registers
   // ---------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_wb_ack_q <= 1'b0;
         o_wb_dat_q <= 32'h0;
      end else begin
         o_wb_ack_q <= i_wb_cyc && i_wb_stb && !o_wb_ack_q;
         if (i_wb_cyc && i_wb_stb && !o_wb_ack_q) begin
            case (i_wb_adr[7:0])
               `AFR_REG_CTRL: o_wb_dat_q <= {24'h0, ctrl_q};
               `AFR_REG_STATUS: o_wb_dat_q <= {14'h0, st_q != ST_IDLE,
                                   fw_active_q, fw_stat_q, fw_exp_q};
               `AFR_REG_COUNT: o_wb_dat_q <= {cnt_sk_q, cnt_err_q};
               default: o_wb_dat_q <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n)
         ctrl_q <= `AFR_CTRL_RST;
      else if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack_q &&
               i_wb_sel[0] && i_wb_adr[7:0] == `AFR_REG_CTRL)
         ctrl_q <= i_wb_dat[7:0];
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         cnt_err_q <= 16'h0;
         cnt_sk_q <= 16'h0;
      end else begin
         if (is_dest && (bad_if || busy_if))
            cnt_err_q <= cnt_err_q + 16'h1;
         if (sk_begin)
            cnt_sk_q <= cnt_sk_q + 16'h1;
      end
   end

   assign o_wb_ack = o_wb_ack_q;
   assign o_wb_dat = o_wb_dat_q;
   assign o_sk_start = o_sk_start_q;
   assign o_sk_dready = o_sk_dready_q;
   assign o_in_ready = o_in_ready_q;
   assign o_out_valid = o_out_valid_q;
   assign o_out_data = o_out_data_q;
   assign o_out_last = o_out_last_q;
   assign o_out_dst = o_out_dst_q;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   sequence s_dest_seen;
      is_dest && rl_id_q != 8'h00;
   endsequence
   sequence s_sock_hdr;
      hdr_q[0] == `AFR_T_SOCK_RX && hdr_n_q == `AFR_SOCK_HDR_LEN;
   endsequence

   a_sock_hdr_type: assert property (
      o_sk_start_q |-> s_sock_hdr ##0 st_q == ST_HDR)
      else $error("socket header type wrong");
   a_sock_proto_map: assert property (
      o_sk_start_q |-> hdr_q[9] ==
      ($past(i_sk_kind) == AFR_TCP ? `AFR_PROTO_TCP :
       $past(i_sk_kind) == AFR_SSL ? `AFR_PROTO_SSL : `AFR_PROTO_UDP))
      else $error("transport code wrong");
   a_sock_rsvd_zero: assert property (
      o_sk_start_q |-> hdr_q[10] == 8'h00 &&
      hdr_q[1] == $past(i_sk_ip[31:24]))
      else $error("reserved byte or address wrong");
   // counter stops at the cap while the tail drains
   a_pay_cap: assert property (
      sk_take && st_q == ST_SKP && sk_cnt_q == CW'(P_MAX_PAYLOAD - 1)
      |=> o_out_last_q && st_q != ST_SKP &&
      sk_cnt_q == CW'(P_MAX_PAYLOAD))
      else $error("payload cap missed");
   a_bad_iface: assert property (
      s_dest_seen ##0 bad_if |=>
      hdr_q[0] == `AFR_T_TX_STATUS && hdr_q[2] == `AFR_ST_BAD_IF)
      else $error("invalid interface not reported");
   a_busy_iface: assert property (
      s_dest_seen ##0 busy_if |=>
      hdr_q[2] == `AFR_ST_BUSY_IF && hdr_q[1] == $past(rl_id_q))
      else $error("busy interface not reported");
   a_zero_id_quiet: assert property (
      is_dest && rl_id_q == 8'h00 && (bad_if || busy_if)
      |=> st_q != ST_HDR)
      else $error("status sent for zero id");
   a_relay_route: assert property (
      relay_ok |=> hdr_q[0] == `AFR_T_RELAY_OUT &&
      route_q == $past(i_in_data[1:0]) &&
      hdr_q[1][1:0] == $past(i_in_src))
      else $error("relay output header wrong");
   a_fw_reply: assert property (
      respond_fire |=> st_q == ST_HDR &&
      hdr_q[0] == `AFR_T_FW_RESP && hdr_q[1] == fw_id_q)
      else $error("update response missing");
endmodule
`default_nettype wire

// *** api_frame_relay_and_update_tb_top.sv ***
// self-checking bench for the frame engine
// assumes afr_host_model sinks egress and the engine answers wishbone
`include "afr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module api_frame_relay_and_update_tb_top;
   import afr_pkg::*;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   localparam int MAXP = 8;
   logic mclk, rst_n, cyc, stb, we, ack, sk_v, sk_start, sk_dv, sk_dl;
   logic sk_rdy, in_v, in_l, in_rdy, out_v, out_l, out_rdy, stall;
   logic [7:0] adr, sk_d, in_d, out_d;
   logic [31:0] wdat, rdat, sk_ip, r, ip;
   logic [15:0] sk_lp, sk_rp;
   logic [1:0] in_src, out_dst, s;
   logic [3:0] dst_acc;
   afr_proto_t sk_kind;
   logic [10:0] exp_q[$];
   logic [7:0] q[$];
   logic [23:0] upd[9] = '{24'h100100, 24'h110000, 24'h130004,
      24'h120200, 24'h130003, 24'h140403, 24'h200100, 24'h210102,
      24'h220401};
   int err_count, total_checks, k, i, len;
   afr_top #(.P_MAX_PAYLOAD(MAXP), .P_AW(8)) dut (.i_mclk(mclk),
      .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_ack(ack),
      .o_wb_dat(rdat), .i_sk_valid(sk_v), .i_sk_ip(sk_ip),
      .i_sk_lport(sk_lp), .i_sk_rport(sk_rp), .i_sk_kind(sk_kind),
      .o_sk_start(sk_start), .i_sk_dvalid(sk_dv), .i_sk_data(sk_d),
      .i_sk_dlast(sk_dl), .o_sk_dready(sk_rdy), .i_in_valid(in_v),
      .i_in_data(in_d), .i_in_last(in_l), .i_in_src(in_src),
      .o_in_ready(in_rdy), .i_dst_accept(dst_acc), .o_out_valid(out_v),
      .o_out_data(out_d), .o_out_last(out_l), .o_out_dst(out_dst),
      .i_out_ready(out_rdy));
   afr_host_model host (.i_mclk(mclk), .i_valid(out_v), .i_data(out_d),
      .i_last(out_l), .i_dst(out_dst), .i_stall(stall), .o_ready(out_rdy));
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic fail(input string m);
      err_count++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic tmo();
      fail("wait ran out");
      end_of_test();
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
         fail($sformatf("word %h exp %h", g, e));
   endtask
   task automatic chk11(input logic [10:0] g, input logic [10:0] e);
      total_checks++;
      // update store bytes carry no framing, so last is not compared
      if (e[9:8] == 2'h3) begin
         g[10] = 1'b0;
         e[10] = 1'b0;
      end
      if (g !== e)
         fail($sformatf("out %h exp %h", g, e));
   endtask
   // which: 0 ack, 1 ingress ready, 2 socket start, 3 payload ready
   function automatic logic pick(input int which);
      case (which)
         0: return ack;
         1: return in_rdy;
         2: return sk_start;
         default: return sk_rdy;
      endcase
   endfunction
   task automatic wt(input int which);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pick(which) !== 1'b1 && n < 400);
      if (pick(which) !== 1'b1)
         tmo();
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd);
      @(posedge mclk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      wt(0);
      rd = rdat;
      {cyc, stb, we} <= 3'b000;
   endtask
   task automatic send(input logic [1:0] src, input logic [7:0] b[$]);
      @(posedge mclk);
      foreach (b[j]) begin
         {in_v, in_l, in_d, in_src} <= {1'b1, j == b.size() - 1, b[j], src};
         wt(1);
      end
      in_v <= 1'b0;
      in_d <= ~b[b.size() - 1];
   endtask
   task automatic sock(input logic [31:0] a, input int kk, input int n);
      @(posedge mclk);
      {sk_v, sk_ip, sk_lp, sk_rp} <= {1'b1, a, 16'h1234, 16'h8001 + 16'(kk)};
      sk_kind <= afr_proto_t'(kk);
      wt(2);
      sk_v <= 1'b0;
      for (int j = 0; j < n; j++) begin
         {sk_dv, sk_dl, sk_d} <= {1'b1, j == n - 1, 8'h30 + 8'(j)};
         wt(3);
      end
      sk_dv <= 1'b0;
   endtask
   task automatic ex(input logic [1:0] d, input logic [7:0] b[$]);
      foreach (b[j])
         exp_q.push_back({j == b.size() - 1, d, b[j]});
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (host.cap_q.size() < exp_q.size() && n < 4000) begin
         @(posedge mclk);
         n++;
      end
      // settle so that a frame that should stay silent would show up
      repeat (40) @(posedge mclk);
      chk32(32'(host.cap_q.size()), 32'(exp_q.size()));
      foreach (exp_q[j])
         if (j < host.cap_q.size())
            chk11(host.cap_q[j], exp_q[j]);
      host.cap_q.delete();
      exp_q.delete();
   endtask
   // ---------------------------------------------
   // run
   // ---------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      repeat (100000) @(posedge mclk);
      tmo();
   end
   initial begin
      {cyc, stb, we, sk_v, sk_dv, sk_dl, in_v, in_l, stall, rst_n} = '0;
      {adr, wdat, sk_ip, sk_lp, sk_rp, sk_d, in_d, in_src} = '0;
      sk_kind = AFR_UDP;
      dst_acc = 4'hf;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      wb(1'b0, 8'h00, 32'h0, r);
      chk32(r, 32'hf1);
      wb(1'b1, 8'h08, 32'hffffffff, r);
      wb(1'b0, 8'h08, 32'h0, r);
      chk32(r, 32'h0);
      wb(1'b0, 8'h0c, 32'h0, r);
      chk32(r, 32'h0);
      stall <= 1'b1;
      for (k = 0; k < 3; k++) begin
         len = (k == 2) ? MAXP + 2 : 3;
         ip = 32'hc0a80068 + 32'(k);
         sock(ip, k, len);
         q = '{8'hb0, ip[31:24], ip[23:16], ip[15:8], ip[7:0], 8'h12,
            8'h34, 8'h80, 8'h01 + 8'(k), (k == 2) ? 8'h04 : 8'(k), 8'h00};
         for (i = 0; i < len && i < MAXP; i++)
            q.push_back(8'h30 + 8'(i));
         ex(2'h0, q);
      end
      drain();
      stall <= 1'b0;
      for (k = 0; k < 3; k++) begin
         s = (k == 0) ? 2'h1 : 2'h0;
         send(s, '{8'h2d, 8'h40 + 8'(k), 8'(k), 8'ha0 + 8'(k), 8'hb0});
         ex(2'(k), '{8'had, {6'h0, s}, 8'ha0 + 8'(k), 8'hb0});
      end
      send(2'h0, '{8'h2d, 8'h55, 8'h03, 8'h01});
      ex(2'h0, '{8'h89, 8'h55, 8'h7c});
      send(2'h1, '{8'h2d, 8'h00, 8'h03, 8'h01});
      dst_acc <= 4'he;
      send(2'h2, '{8'h2d, 8'h66, 8'h00, 8'h01});
      ex(2'h2, '{8'h89, 8'h66, 8'h7d});
      dst_acc <= 4'hf;
      wb(1'b1, 8'h00, 32'hb1, r);
      send(2'h0, '{8'h2d, 8'h67, 8'h02, 8'h01});
      ex(2'h0, '{8'h89, 8'h67, 8'h7d});
      wb(1'b1, 8'h00, 32'hf1, r);
      send(2'h0, '{8'h11, 8'h22});
      drain();
      wb(1'b0, 8'h08, 32'h0, r);
      chk32(r, 32'h00030004);
      for (k = 0; k < 9; k++) begin
         send(2'h0, '{8'h2b, upd[k][23:16], 8'h00, upd[k][15:8],
            8'h5a + 8'(k)});
         if (upd[k][7:0] == 8'h00)
            ex(2'h3, '{8'h5a + 8'(k)});
         ex(2'h0, '{8'hab, upd[k][23:16], upd[k][7:0]});
      end
      send(2'h0, '{8'h2b, 8'h30, 8'h00});
      ex(2'h0, '{8'hab, 8'h30, 8'h05});
      drain();
      wb(1'b0, 8'h04, 32'h0, r);
      chk32(r, 32'h00000121);
      end_of_test();
   end
endmodule
`default_nettype wire
